// File: logic/ccr_map.svh
`ifndef CCR_MAP_SVH
`define CCR_MAP_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define CCR_IDX_W 5
`define CCR_IDX_CFG 5'h0E
`define CCR_IDX_OCAL_U 5'h0F
`define CCR_IDX_OCAL_L 5'h10
`define CCR_IDX_GCAL_U 5'h11
`define CCR_IDX_GCAL_L 5'h12

// ----------------------------------------------------------------
// reset values and writable-bit masks
// ----------------------------------------------------------------
`define CCR_RST_CFG 16'h0000
`define CCR_RST_OCAL_U 16'h0000
`define CCR_RST_OCAL_L 16'h0000
`define CCR_RST_GCAL_U 16'h8000
`define CCR_RST_GCAL_L 16'h0000
`define CCR_WMASK_CFG 16'hFFC7
`define CCR_WMASK_UPPER 16'hFFFF
`define CCR_WMASK_LOWER 16'hFF00

// ----------------------------------------------------------------
// configuration word fields
// ----------------------------------------------------------------
`define CCR_PHASE_MSB 15
`define CCR_PHASE_LSB 6
`define CCR_DCOFF_BIT 2
`define CCR_MUX_MSB 1
`define CCR_MUX_LSB 0

// ----------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------
`define CCR_RESP_OKAY 2'h0
`define CCR_RESP_SLVERR 2'h2

`endif

// File: logic/ccr_pkg.sv
`include "ccr_map.svh"

package ccr_pkg;
   typedef logic [15:0] ccr_word_t;
   typedef logic [`CCR_IDX_W-1:0] ccr_idx_t;
   typedef struct packed {
      logic hit;
      ccr_idx_t idx;
   } ccr_dec_t;
   typedef enum logic [1:0] {
      ccr_in_pins = 2'h0,
      ccr_in_short = 2'h1,
      ccr_in_pos_test = 2'h2,
      ccr_in_neg_test = 2'h3
   } ccr_input_t;
endpackage : ccr_pkg

// File: logic/ccr_wr_if.sv
`timescale 1ns/10ps

interface ccr_wr_if;
   import ccr_pkg::*;
   logic wr_en;
   ccr_word_t wdata;
   logic [1:0] wstrb;
   modport src (output wr_en, output wdata, output wstrb);
   modport dst (input wr_en, input wdata, input wstrb);
endinterface : ccr_wr_if

// File: logic/ccr_word_reg.sv
`timescale 1ns/10ps

module ccr_word_reg import ccr_pkg::*; #(
   parameter ccr_word_t RESET_VAL = 16'h0000,
   parameter ccr_word_t WMASK = 16'hFFFF
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic sel,
   ccr_wr_if.dst wr,
   output ccr_word_t q
);
   ccr_word_t lane_mask;

   // reserved bits are outside WMASK, so they never leave reset zero
   assign lane_mask = {{8{wr.wstrb[1]}}, {8{wr.wstrb[0]}}} & WMASK;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= RESET_VAL;
      end else if (wr.wr_en && sel) begin
         q <= (q & ~lane_mask) | (wr.wdata & lane_mask);
      end
   end
endmodule : ccr_word_reg

// File: logic/ccr_cfg_decode.sv
`timescale 1ns/10ps

module ccr_cfg_decode import ccr_pkg::*; #(
   parameter int GDC_W = 4
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [1:0] chan_input_select,
   input wire logic chan_dc_filter_off,
   input wire logic [GDC_W-1:0] global_dc_filter_setting,
   output logic dc_filter_active,
   output logic [3:0] input_path
);
   logic [3:0] next_input_path;

   always_comb begin
      case (ccr_input_t'(chan_input_select))
         ccr_in_pins: next_input_path = 4'h1;
         ccr_in_short: next_input_path = 4'h2;
         ccr_in_pos_test: next_input_path = 4'h4;
         ccr_in_neg_test: next_input_path = 4'h8;
         default: next_input_path = 4'h1;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         input_path <= 4'h1;
      end else begin
         input_path <= next_input_path;
      end
   end

   // a zero global setting means the filter is off for all channels
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dc_filter_active <= 1'b0;
      end else begin
         dc_filter_active <= (global_dc_filter_setting != '0) &&
                             !chan_dc_filter_off;
      end
   end
endmodule : ccr_cfg_decode

// File: logic/ccr_chan_regs.sv
// Function
// - config bits 15:6 hold signed phase delay in modulator cycles, reset zero
// - config bit 2 set disables dc filter here; clear defers to global
// - config bits 1:0 pick input: pins, shorted, positive or negative test
// - upper offset register holds offset bits 23:8, all sixteen bits writable
// - lower offset register holds offset bits 7:0 high; low byte reads zero
// - upper gain register holds gain bits 23:8, all sixteen bits writable
// - lower gain register holds gain bits 7:0 high; low byte reads zero
// - upper gain register sits at index 11h and resets to 8000h
// - upper offset at index Fh, lower at 10h, both reset to zero
// - lower gain register sits at index 12h and resets to zero
`timescale 1ns/10ps
`include "ccr_map.svh"

module ccr_chan_regs import ccr_pkg::*; #(
   parameter int ADDR_W = 8,
   parameter int GDC_W = 4
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [GDC_W-1:0] global_dc_filter_setting,
   output logic [9:0] chan_phase_delay,
   output logic chan_dc_filter_off,
   output logic [1:0] chan_input_select,
   output logic dc_filter_active,
   output logic [3:0] input_path,
   output logic [23:0] offset_cal,
   output logic [23:0] gain_cal
);
   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   function automatic ccr_dec_t ccr_addr_decode(
      input logic [ADDR_W-1:0] a
   );
      ccr_dec_t d;
      d.idx = a[`CCR_IDX_W+1:2];
      d.hit = (a[1:0] == 2'h0) &&
              ((a >> (`CCR_IDX_W + 2)) == '0) &&
              (d.idx >= `CCR_IDX_CFG) && (d.idx <= `CCR_IDX_GCAL_L);
      return d;
   endfunction : ccr_addr_decode

   logic [ADDR_W-1:0] aw_addr_q;
   ccr_word_t w_data_q;
   logic [1:0] w_strb_q;
   logic wr_commit;
   ccr_dec_t wr_dec;
   ccr_dec_t rd_dec;
   ccr_word_t rd_word;
   ccr_word_t cfg_q;
   ccr_word_t ocu_q;
   ccr_word_t ocl_q;
   ccr_word_t gcu_q;
   ccr_word_t gcl_q;

   ccr_wr_if wr ();

   assign wr_dec = ccr_addr_decode(aw_addr_q);
   assign rd_dec = ccr_addr_decode(araddr);

   // ----------------------------------------------------------------
   // write channels: address and data taken in either order
   // ----------------------------------------------------------------
   // both captured and no response pending; one write in flight at most
   assign wr_commit = !awready && !wready && !bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b1;
         aw_addr_q <= '0;
      end else if (awvalid && awready) begin
         awready <= 1'b0;
         aw_addr_q <= awaddr;
      end else if (wr_commit) begin
         awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready <= 1'b1;
         w_data_q <= 16'h0000;
         w_strb_q <= 2'h0;
      end else if (wvalid && wready) begin
         wready <= 1'b0;
         w_data_q <= wdata[15:0];
         w_strb_q <= wstrb[1:0];
      end else if (wr_commit) begin
         wready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp <= `CCR_RESP_OKAY;
      end else if (wr_commit) begin
         bvalid <= 1'b1;
         bresp <= wr_dec.hit ? `CCR_RESP_OKAY : `CCR_RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // upper data lanes have no storage; their strobes are ignored
   assign wr.wr_en = wr_commit && wr_dec.hit;
   assign wr.wdata = w_data_q;
   assign wr.wstrb = w_strb_q;

   // ----------------------------------------------------------------
   // register words
   // ----------------------------------------------------------------
   ccr_word_reg #(
      .RESET_VAL(`CCR_RST_CFG),
      .WMASK(`CCR_WMASK_CFG)
   ) u_cfg (
      .aclk(aclk),
      .aresetn(aresetn),
      .sel(wr_dec.idx == `CCR_IDX_CFG),
      .wr(wr.dst),
      .q(cfg_q)
   );

   ccr_word_reg #(
      .RESET_VAL(`CCR_RST_OCAL_U),
      .WMASK(`CCR_WMASK_UPPER)
   ) u_ocal_u (
      .aclk(aclk),
      .aresetn(aresetn),
      .sel(wr_dec.idx == `CCR_IDX_OCAL_U),
      .wr(wr.dst),
      .q(ocu_q)
   );

   ccr_word_reg #(
      .RESET_VAL(`CCR_RST_OCAL_L),
      .WMASK(`CCR_WMASK_LOWER)
   ) u_ocal_l (
      .aclk(aclk),
      .aresetn(aresetn),
      .sel(wr_dec.idx == `CCR_IDX_OCAL_L),
      .wr(wr.dst),
      .q(ocl_q)
   );

   ccr_word_reg #(
      .RESET_VAL(`CCR_RST_GCAL_U),
      .WMASK(`CCR_WMASK_UPPER)
   ) u_gcal_u (
      .aclk(aclk),
      .aresetn(aresetn),
      .sel(wr_dec.idx == `CCR_IDX_GCAL_U),
      .wr(wr.dst),
      .q(gcu_q)
   );

   ccr_word_reg #(
      .RESET_VAL(`CCR_RST_GCAL_L),
      .WMASK(`CCR_WMASK_LOWER)
   ) u_gcal_l (
      .aclk(aclk),
      .aresetn(aresetn),
      .sel(wr_dec.idx == `CCR_IDX_GCAL_L),
      .wr(wr.dst),
      .q(gcl_q)
   );

   // ----------------------------------------------------------------
   // fields toward the converter datapath
   // ----------------------------------------------------------------
   assign chan_phase_delay = cfg_q[`CCR_PHASE_MSB:`CCR_PHASE_LSB];
   assign chan_dc_filter_off = cfg_q[`CCR_DCOFF_BIT];
   assign chan_input_select = cfg_q[`CCR_MUX_MSB:`CCR_MUX_LSB];
   assign offset_cal = {ocu_q, ocl_q[15:8]};
   assign gain_cal = {gcu_q, gcl_q[15:8]};

   ccr_cfg_decode #(
      .GDC_W(GDC_W)
   ) u_decode (
      .aclk(aclk),
      .aresetn(aresetn),
      .chan_input_select(chan_input_select),
      .chan_dc_filter_off(chan_dc_filter_off),
      .global_dc_filter_setting(global_dc_filter_setting),
      .dc_filter_active(dc_filter_active),
      .input_path(input_path)
   );

   // ----------------------------------------------------------------
   // read channel
   // ----------------------------------------------------------------
   always_comb begin
      case (rd_dec.idx)
         `CCR_IDX_CFG: rd_word = cfg_q;
         `CCR_IDX_OCAL_U: rd_word = ocu_q;
         `CCR_IDX_OCAL_L: rd_word = ocl_q;
         `CCR_IDX_GCAL_U: rd_word = gcu_q;
         `CCR_IDX_GCAL_L: rd_word = gcl_q;
         default: rd_word = 16'h0000;
      endcase
   end

   // read sees the pre-write value if a write commits on the same edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= `CCR_RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= rd_dec.hit ? {16'h0000, rd_word} : 32'h0000_0000;
         rresp <= rd_dec.hit ? `CCR_RESP_OKAY : `CCR_RESP_SLVERR;
      end else if (rvalid && rready) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_commit_to(logic [`CCR_IDX_W-1:0] idx, logic [1:0] strb);
      wr_commit && wr_dec.hit && wr_dec.idx == idx && w_strb_q == strb;
   endsequence

   sequence s_read_of(logic [`CCR_IDX_W-1:0] idx);
      arvalid && arready && rd_dec.hit && rd_dec.idx == idx;
   endsequence

   property p_phase_write;
      s_commit_to(`CCR_IDX_CFG, 2'h3) |=>
         chan_phase_delay == $past(w_data_q[15:6]);
   endproperty
   a_phase_write: assert property (p_phase_write)
      else $error("phase delay field not loaded from write");

   property p_dc_filter;
      s_commit_to(`CCR_IDX_CFG, 2'h3) ##1 1'b1 |=>
         dc_filter_active == ($past(global_dc_filter_setting, 1) != '0 &&
                              !$past(w_data_q[2], 2));
   endproperty
   a_dc_filter: assert property (p_dc_filter)
      else $error("dc filter enable does not follow disable bit");

   property p_input_path;
      ##1 input_path == (4'h1 << $past(chan_input_select));
   endproperty
   a_input_path: assert property (p_input_path)
      else $error("input path does not match selector code");

   property p_ocal_upper;
      s_commit_to(`CCR_IDX_OCAL_U, 2'h3) |=>
         offset_cal[23:8] == $past(w_data_q);
   endproperty
   a_ocal_upper: assert property (p_ocal_upper)
      else $error("upper offset word not loaded");

   // compare against the pre-edge value: a write may commit on that edge
   property p_ocal_lower_read;
      s_read_of(`CCR_IDX_OCAL_L) |=>
         rvalid && rdata[7:0] == 8'h00 &&
         rdata[15:8] == $past(offset_cal[7:0]);
   endproperty
   a_ocal_lower_read: assert property (p_ocal_lower_read)
      else $error("lower offset read wrong or low byte nonzero");

   property p_gcal_upper;
      s_commit_to(`CCR_IDX_GCAL_U, 2'h3) |=>
         gain_cal[23:8] == $past(w_data_q);
   endproperty
   a_gcal_upper: assert property (p_gcal_upper)
      else $error("upper gain word not loaded");

   property p_gcal_lower_read;
      s_read_of(`CCR_IDX_GCAL_L) |=>
         rvalid && rdata[7:0] == 8'h00 &&
         rdata[15:8] == $past(gain_cal[7:0]);
   endproperty
   a_gcal_lower_read: assert property (p_gcal_lower_read)
      else $error("lower gain read wrong or low byte nonzero");

   property p_gain_reset;
      $rose(aresetn) |-> gain_cal == 24'h80_0000;
   endproperty
   a_gain_reset: assert property (@(posedge aclk) p_gain_reset)
      else $error("gain calibration reset value wrong");

   property p_offset_reset;
      $rose(aresetn) |-> offset_cal == 24'h00_0000 && cfg_q == 16'h0000;
   endproperty
   a_offset_reset: assert property (@(posedge aclk) p_offset_reset)
      else $error("offset or config reset value wrong");

   property p_gain_addr;
      arvalid && arready && araddr == ADDR_W'({`CCR_IDX_GCAL_U, 2'h0}) |=>
         rdata[15:0] == $past(gain_cal[23:8]) &&
         rresp == `CCR_RESP_OKAY;
   endproperty
   a_gain_addr: assert property (p_gain_addr)
      else $error("upper gain word not at its address");

   property p_reserved_zero;
      cfg_q[5:3] == 3'h0 && ocl_q[7:0] == 8'h00 && gcl_q[7:0] == 8'h00;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved bits took a written value");

   property p_bvalid_hold;
      bvalid && !bready |=> bvalid && $stable(bresp);
   endproperty
   a_bvalid_hold: assert property (p_bvalid_hold)
      else $error("write response dropped before taken");

   property p_rvalid_hold;
      rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
   endproperty
   a_rvalid_hold: assert property (p_rvalid_hold)
      else $error("read data dropped before taken");

   property p_refused_write;
      wr_commit && !wr_dec.hit |=>
         $stable(cfg_q) && $stable(ocu_q) && $stable(ocl_q) &&
         $stable(gcu_q) && $stable(gcl_q);
   endproperty
   a_refused_write: assert property (p_refused_write)
      else $error("refused write changed a register");
endmodule : ccr_chan_regs

// File: dv/tb_ccr_chan_regs.sv
`timescale 1ns/10ps
`include "ccr_map.svh"

module tb_ccr_chan_regs;
   // ----------------------------------------------------------------
   // byte addresses, four times the register index
   // ----------------------------------------------------------------
   localparam logic [7:0] A_CFG = {1'b0, `CCR_IDX_CFG, 2'b00};
   localparam logic [7:0] A_OCU = {1'b0, `CCR_IDX_OCAL_U, 2'b00};
   localparam logic [7:0] A_OCL = {1'b0, `CCR_IDX_OCAL_L, 2'b00};
   localparam logic [7:0] A_GCU = {1'b0, `CCR_IDX_GCAL_U, 2'b00};
   localparam logic [7:0] A_GCL = {1'b0, `CCR_IDX_GCAL_L, 2'b00};
   localparam logic [1:0] OK = `CCR_RESP_OKAY;
   localparam logic [1:0] ERR = `CCR_RESP_SLVERR;

   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic awvalid = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic [7:0] araddr = 8'h00;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic [3:0] global_dc_filter_setting = 4'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, chan_input_select;
   logic [31:0] rdata;
   logic [9:0] chan_phase_delay;
   logic chan_dc_filter_off, dc_filter_active;
   logic [3:0] input_path;
   logic [23:0] offset_cal, gain_cal;
   int miscompares = 0;
   int n_tests = 0;
   int cycles = 0;
   logic [7:0] bad_addr [5] = '{8'h00, 8'h34, 8'h4C, 8'h3D, 8'hC4};

   initial begin
      forever #10 aclk = ~aclk;
   end

   ccr_chan_regs #(.ADDR_W(8), .GDC_W(4)) i_dut (
      .aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .global_dc_filter_setting(global_dc_filter_setting),
      .chan_phase_delay(chan_phase_delay),
      .chan_dc_filter_off(chan_dc_filter_off),
      .chan_input_select(chan_input_select),
      .dc_filter_active(dc_filter_active), .input_path(input_path),
      .offset_cal(offset_cal), .gain_cal(gain_cal)
   );

   // ----------------------------------------------------------------
   // checking and closing
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check

   task automatic report_and_stop();
      $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : report_and_stop

   // generous ceiling: the whole sequence needs well under 1000 cycles
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         $display("unexpected hang: bench cycle ceiling reached");
         report_and_stop();
      end
   end

   // ----------------------------------------------------------------
   // bus tasks
   // ----------------------------------------------------------------
   // upper data half carries junk on purpose: it must never be stored
   task automatic wchk(input logic [7:0] a, input logic [15:0] d,
                       input logic [3:0] s, input logic [1:0] exp_resp);
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {16'hA5A5, d};
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge aclk);
         if (awvalid && awready === 1'b1) begin
            awvalid <= 1'b0;
            aw_done = 1'b1;
         end
         if (wvalid && wready === 1'b1) begin
            wvalid <= 1'b0;
            w_done = 1'b1;
         end
      end
      // ready only after valid is seen, so the slave must hold its answer
      do @(posedge aclk); while (bvalid !== 1'b1);
      bready <= 1'b1;
      do @(posedge aclk); while (bvalid !== 1'b1);
      check("bresp", {30'h0, bresp}, {30'h0, exp_resp});
      bready <= 1'b0;
   endtask : wchk

   task automatic rchk(input string what, input logic [7:0] a,
                       input logic [15:0] exp_d, input logic [1:0] exp_resp);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rready <= 1'b1;
      do @(posedge aclk); while (rvalid !== 1'b1);
      check(what, rdata, {16'h0, exp_d});
      check("rresp", {30'h0, rresp}, {30'h0, exp_resp});
      rready <= 1'b0;
   endtask : rchk

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;

      rchk("cfg after reset", A_CFG, 16'h0000, OK);
      rchk("ocal upper after reset", A_OCU, 16'h0000, OK);
      rchk("ocal lower after reset", A_OCL, 16'h0000, OK);
      rchk("gcal upper after reset", A_GCU, 16'h8000, OK);
      rchk("gcal lower after reset", A_GCL, 16'h0000, OK);
      check("gain_cal after reset", gain_cal, 32'h800000);
      check("offset_cal after reset", offset_cal, 32'h0);
      check("phase after reset", chan_phase_delay, 32'h0);
      check("dc off after reset", chan_dc_filter_off, 32'h0);
      check("input path after reset", input_path, 32'h1);
      $display("test reset values done");

      // all ones everywhere: reserved positions must stay clear
      wchk(A_CFG, 16'hFFFF, 4'hF, OK);
      wchk(A_OCU, 16'hFFFF, 4'hF, OK);
      wchk(A_OCL, 16'hFFFF, 4'hF, OK);
      wchk(A_GCU, 16'hFFFF, 4'hF, OK);
      wchk(A_GCL, 16'hFFFF, 4'hF, OK);
      rchk("cfg all ones", A_CFG, 16'hFFC7, OK);
      rchk("ocal upper all ones", A_OCU, 16'hFFFF, OK);
      rchk("ocal lower all ones", A_OCL, 16'hFF00, OK);
      rchk("gcal upper all ones", A_GCU, 16'hFFFF, OK);
      rchk("gcal lower all ones", A_GCL, 16'hFF00, OK);
      check("offset_cal all ones", offset_cal, 32'hFFFFFF);
      check("gain_cal all ones", gain_cal, 32'hFFFFFF);
      $display("test reserved bits done");

      // byte strobes on upper and lower words
      wchk(A_OCU, 16'h1234, 4'hF, OK);
      wchk(A_OCL, 16'hABCD, 4'hF, OK);
      wchk(A_OCU, 16'h5600, 4'h2, OK);
      wchk(A_GCL, 16'h12FF, 4'h1, OK);
      rchk("ocal upper strobed", A_OCU, 16'h5634, OK);
      rchk("ocal lower value", A_OCL, 16'hAB00, OK);
      rchk("gcal lower strobed", A_GCL, 16'hFF00, OK);
      check("offset_cal strobed", offset_cal, 32'h5634AB);
      $display("test byte strobes done");

      // every input code, negative phase, filter override
      for (int m = 0; m < 4; m++) begin
         global_dc_filter_setting <= (m > 1) ? 4'h8 : 4'h0;
         wchk(A_CFG, {10'h201, 3'b111, m[0], m[1:0]}, 4'hF, OK);
         repeat (2) @(posedge aclk);
         rchk("cfg code", A_CFG, {10'h201, 3'b000, m[0], m[1:0]}, OK);
         check("input select", chan_input_select, m);
         check("input path", input_path, 32'h1 << m);
         check("phase delay", chan_phase_delay, 32'h201);
         check("dc filter off", chan_dc_filter_off, m & 1);
         check("dc filter active", dc_filter_active, m == 2);
      end
      $display("test configuration codes done");

      // unmapped and misaligned places change nothing
      foreach (bad_addr[i]) begin
         wchk(bad_addr[i], 16'h0000, 4'hF, ERR);
         rchk("unmapped read", bad_addr[i], 16'h0000, ERR);
      end
      rchk("gcal upper kept", A_GCU, 16'hFFFF, OK);
      rchk("ocal upper kept", A_OCU, 16'h5634, OK);
      $display("test unmapped accesses done");

      report_and_stop();
   end
endmodule : tb_ccr_chan_regs
